/* logic/lsd_segment_top.sv */
// Segment pattern generator: plane select, blink, hex decode
// ==========================================================
`timescale 1ns/1ps
module lsd_segment_top #(
   parameter int SLOW_PHASE_CYC = lsd_pkg::LSD_SLOW_PHASE_CYC,
   parameter int FAST_PHASE_CYC = lsd_pkg::LSD_FAST_PHASE_CYC,
   parameter int DIGIT_CYC = lsd_pkg::LSD_DIGIT_CYC
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic WR_STB,
   input wire logic CS_RISE,
   input wire logic [7:0] WR_ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_FIRST_PLANE,
   input wire logic WR_SECOND_PLANE,
   input wire logic [2:0] WR_DIGIT,
   output logic [6:0] SEGMENTS,
   output logic DECIMAL_POINT_SEGMENT,
   output logic [2:0] DIGIT_INDEX,
   output logic BLINK_PHASE,
   output logic [7:0] DECODE_SELECT
);
   import lsd_pkg::*;

   // ==========================================================
   // Elaboration checks
   // Counters are 32 bits wide; a zero length would wrap the limit and stretch a phase or dwell to 2^32 cycles
   if (FAST_PHASE_CYC < 1) begin : g_bad_fast
      $error("lsd_segment_top: FAST_PHASE_CYC must be at least 1");
   end
   if (SLOW_PHASE_CYC < FAST_PHASE_CYC) begin : g_bad_slow
      $error("lsd_segment_top: SLOW_PHASE_CYC below FAST_PHASE_CYC");
   end
   if (DIGIT_CYC < 2) begin : g_bad_dwell
      $error("lsd_segment_top: DIGIT_CYC must be at least 2");
   end

   // ==========================================================
   // Hex font, segments a..g with a as MSB
   function automatic logic [6:0] hex_font(input logic [3:0] nib);
      logic [6:0] s;
      s = 7'h00;
      case (nib)
         4'h0: s = 7'h7e;
         4'h1: s = 7'h30;
         4'h2: s = 7'h6d;
         4'h3: s = 7'h79;
         4'h4: s = 7'h33;
         4'h5: s = 7'h5b;
         4'h6: s = 7'h5f;
         4'h7: s = 7'h70;
         4'h8: s = 7'h7f;
         4'h9: s = 7'h7b;
         4'ha: s = 7'h77;
         4'hb: s = 7'h1f;
         4'hc: s = 7'h4e;
         4'hd: s = 7'h3d;
         4'he: s = 7'h4f;
         default: s = 7'h47;
      endcase
      return s;
   endfunction : hex_font

   // ==========================================================
   // Counter step, shared by the blink and scan dividers
   function automatic logic [31:0] cnt_step(input logic [31:0] cnt, input logic wrap);
      logic [31:0] n;
      n = cnt + 32'h1;
      if (wrap) n = 32'h0;
      return n;
   endfunction : cnt_step

   // ==========================================================
   // Registers
   logic [7:0] decode_sel_ff;
   logic blink_en_ff;
   logic fast_rate_ff;
   logic sync_pend_ff;
   logic [31:0] phase_cnt_ff;
   logic phase_ff;
   logic [31:0] digit_cnt_ff;
   logic [2:0] scan_idx_ff;
   logic [2:0] shown_idx_ff;
   logic shown_phase_ff;
   logic [6:0] seg_ff;
   logic dp_ff;

   // ==========================================================
   // Write decode
   // A plane write is never also a register write, whatever its address
   wire wr_plane = WR_FIRST_PLANE || WR_SECOND_PLANE;
   wire wr_reg = WR_STB && !wr_plane;
   wire wr_decode = wr_reg && (WR_ADDR == LSD_DECODE_SEL_ADDR);
   wire wr_config = wr_reg && (WR_ADDR == LSD_CONFIG_ADDR);
   wire wr_sync = wr_config && WR_DATA[LSD_CFG_SYNC_BIT];
   wire wr_first_en = WR_STB && WR_FIRST_PLANE;
   wire wr_second_en = WR_STB && WR_SECOND_PLANE;

   // ==========================================================
   // Configuration next state
   wire [7:0] nxt_decode_sel = wr_decode ? WR_DATA : decode_sel_ff;
   wire nxt_blink_en = wr_config ? WR_DATA[LSD_CFG_BLINK_EN_BIT] : blink_en_ff;
   wire nxt_fast_rate = wr_config ? WR_DATA[LSD_CFG_RATE_BIT] : fast_rate_ff;
   // Sync also fires when the write and the chip-select rise share a cycle
   wire sync_now = CS_RISE && (sync_pend_ff || wr_sync);
   // Counters clear only once chip select rises, not at the write
   wire nxt_sync_pend = CS_RISE ? 1'h0 : (wr_config ? wr_sync : sync_pend_ff);

   // ==========================================================
   // Blink and scan dividers
   wire [31:0] phase_len = fast_rate_ff ? 32'(FAST_PHASE_CYC) : 32'(SLOW_PHASE_CYC);
   // A rate change can leave the count past the new length, so end the phase at once
   wire phase_end = (phase_cnt_ff >= phase_len - 32'h1);
   wire digit_end = (digit_cnt_ff >= 32'(DIGIT_CYC - 1));
   wire [31:0] nxt_phase_cnt = sync_now ? 32'h0 : cnt_step(phase_cnt_ff, phase_end);
   wire nxt_phase = sync_now ? 1'h0 : (phase_ff ^ phase_end);
   wire [31:0] nxt_digit_cnt = sync_now ? 32'h0 : cnt_step(digit_cnt_ff, digit_end);
   wire [2:0] nxt_scan_idx = sync_now ? 3'h0 : (scan_idx_ff + {2'h0, digit_end});

   // ==========================================================
   // Plane memory
   // Read with the next index so the registered data lines up with scan_idx_ff
   logic [7:0] first_byte;
   logic [7:0] second_byte;
   lsd_plane_mem u_mem (
      .CLK(CLK),
      .RSTN(RSTN),
      .CE(CE),
      .clr(1'h0),
      .wr_first(wr_first_en),
      .wr_second(wr_second_en),
      .wr_idx(WR_DIGIT),
      .wr_data(WR_DATA),
      .rd_idx(nxt_scan_idx),
      .rd_first(first_byte),
      .rd_second(second_byte)
   );

   // ==========================================================
   // Segment pattern
   // Second plane is only ever seen while blinking, in the second half
   wire use_second = blink_en_ff && phase_ff;
   wire [7:0] sel_byte = use_second ? second_byte : first_byte;
   wire hex_mode = decode_sel_ff[scan_idx_ff];
   wire [6:0] font_seg = hex_font(sel_byte[3:0]);
   wire [6:0] raw_seg = sel_byte[6:0];
   wire [6:0] nxt_seg = hex_mode ? font_seg : raw_seg;
   wire nxt_dp = sel_byte[LSD_DP_BIT];

   // ==========================================================
   // Configuration registers
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         decode_sel_ff <= LSD_DECODE_SEL_RESET;
         blink_en_ff <= LSD_CONFIG_RESET[LSD_CFG_BLINK_EN_BIT];
         fast_rate_ff <= LSD_CONFIG_RESET[LSD_CFG_RATE_BIT];
         sync_pend_ff <= 1'h0;
      end else if (CE) begin
         decode_sel_ff <= nxt_decode_sel;
         blink_en_ff <= nxt_blink_en;
         fast_rate_ff <= nxt_fast_rate;
         sync_pend_ff <= nxt_sync_pend;
      end
   end

   // ==========================================================
   // Divider registers
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         phase_cnt_ff <= 32'h0;
         phase_ff <= 1'h0;
         digit_cnt_ff <= 32'h0;
         scan_idx_ff <= 3'h0;
      end else if (CE) begin
         phase_cnt_ff <= nxt_phase_cnt;
         phase_ff <= nxt_phase;
         digit_cnt_ff <= nxt_digit_cnt;
         scan_idx_ff <= nxt_scan_idx;
      end
   end

   // ==========================================================
   // Output registers
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         seg_ff <= 7'h00;
         dp_ff <= 1'h0;
         shown_idx_ff <= 3'h0;
         shown_phase_ff <= 1'h0;
      end else if (CE) begin
         // Index and phase travel with the pattern so the outputs always agree
         seg_ff <= nxt_seg;
         dp_ff <= nxt_dp;
         shown_idx_ff <= scan_idx_ff;
         shown_phase_ff <= phase_ff;
      end
   end

   // ==========================================================
   // Ports
   assign SEGMENTS = seg_ff;
   assign DECIMAL_POINT_SEGMENT = dp_ff;
   assign DIGIT_INDEX = shown_idx_ff;
   assign BLINK_PHASE = shown_phase_ff;
   assign DECODE_SELECT = decode_sel_ff;
endmodule : lsd_segment_top

/* inc/lsd_pkg.sv */
// Shared constants for the LED segment decode and blink select block
package lsd_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] LSD_DECODE_SEL_ADDR = 8'h01;
   localparam logic [7:0] LSD_CONFIG_ADDR = 8'h04;
   localparam logic [7:0] LSD_DECODE_SEL_RESET = 8'h00;
   localparam logic [7:0] LSD_CONFIG_RESET = 8'h00;
   // ==========================================================
   // Configuration fields
   localparam int LSD_CFG_RATE_BIT = 2;
   localparam int LSD_CFG_BLINK_EN_BIT = 3;
   localparam int LSD_CFG_SYNC_BIT = 4;
   // ==========================================================
   // Data byte fields
   localparam int LSD_DP_BIT = 7;
   // ==========================================================
   // Timing
   localparam int LSD_MUX_CLK_HZ = 20000000;
   localparam int LSD_REF_CLK_HZ = 4000000;
   localparam int LSD_SLOW_PHASE_MS = 1000;
   localparam int LSD_FAST_PHASE_MS = 500;
   localparam int LSD_SLOW_PHASE_CYC = LSD_MUX_CLK_HZ / 1000 * LSD_SLOW_PHASE_MS;
   localparam int LSD_FAST_PHASE_CYC = LSD_MUX_CLK_HZ / 1000 * LSD_FAST_PHASE_MS;
   localparam int LSD_NUM_DIGITS = 8;
   localparam int LSD_DIGIT_CYC = 4000;
endpackage : lsd_pkg

/* logic/lsd_plane_mem.sv */
// Two-plane digit memory with registered read
`timescale 1ns/1ps
module lsd_plane_mem (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic clr,
   input wire logic wr_first,
   input wire logic wr_second,
   input wire logic [2:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [2:0] rd_idx,
   output logic [7:0] rd_first,
   output logic [7:0] rd_second
);
   logic [7:0] first_mem [0:7];
   logic [7:0] second_mem [0:7];
   // ==========================================================
   // Storage
   always_ff @(posedge CLK) begin
      if (!RSTN || (CE && clr)) begin
         for (int i = 0; i < 8; i++) begin
            first_mem[i] <= 8'h00;
            second_mem[i] <= 8'h00;
         end
      end else if (CE) begin
         if (wr_first) first_mem[wr_idx] <= wr_data;
         if (wr_second) second_mem[wr_idx] <= wr_data;
      end
   end
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         rd_first <= 8'h00;
         rd_second <= 8'h00;
      end else if (CE) begin
         rd_first <= first_mem[rd_idx];
         rd_second <= second_mem[rd_idx];
      end
   end
endmodule : lsd_plane_mem

/* bench/lsd_segment_chk.sv */
// Port checker for the segment decode block
`timescale 1ns/1ps
module lsd_segment_chk (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic WR_STB,
   input wire logic CS_RISE,
   input wire logic [7:0] WR_ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic WR_FIRST_PLANE,
   input wire logic WR_SECOND_PLANE,
   input wire logic [6:0] SEGMENTS,
   input wire logic [2:0] DIGIT_INDEX,
   input wire logic BLINK_PHASE,
   input wire logic [7:0] DECODE_SELECT
);
   // ==========================================================
   // Write decode
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   wire logic reg_wr = CE && WR_STB && !WR_FIRST_PLANE && !WR_SECOND_PLANE;
   wire logic dec_wr = reg_wr && WR_ADDR == 8'h01;
   wire logic sync_wr = reg_wr && WR_ADDR == 8'h04 && WR_DATA[4];
   // ==========================================================
   // Assertions
   a_reset_clear: assert property ($rose(RSTN) |-> DECODE_SELECT == 8'h00)
      else $error("decode select not cleared");
   a_decode_copy: assert property (dec_wr |=> DECODE_SELECT == $past(WR_DATA))
      else $error("decode select not written");
   a_decode_only: assert property ($changed(DECODE_SELECT) |-> $past(dec_wr))
      else $error("decode select changed unasked");
   a_sync_restart: assert property (sync_wr ##1 (CS_RISE && CE) |->
      ##[1:2] (DIGIT_INDEX == 3'h0 && !BLINK_PHASE)) else $error("sync did not restart");
   a_scan_order: assert property ($changed(DIGIT_INDEX) |->
      DIGIT_INDEX == 3'h0 || DIGIT_INDEX == $past(DIGIT_INDEX) + 3'h1)
      else $error("digit scan out of order");
   // Sync may legally cut a dwell short, so recent chip-select rises are excused
   a_digit_dwell: assert property ($changed(DIGIT_INDEX) ##1 (!CS_RISE && !$past(CS_RISE))
      |=> $stable(DIGIT_INDEX)) else $error("digit dwell too short");
   a_phase_hold: assert property ($changed(BLINK_PHASE) ##1 (!CS_RISE && !$past(CS_RISE))
      |=> $stable(BLINK_PHASE)) else $error("blink phase too short");
   a_ce_freeze: assert property (!CE |=> $stable({SEGMENTS, DIGIT_INDEX, BLINK_PHASE}))
      else $error("state moved with enable low");
endmodule : lsd_segment_chk
bind lsd_segment_top lsd_segment_chk chk (.CLK(CLK), .RSTN(RSTN), .CE(CE), .WR_STB(WR_STB),
   .CS_RISE(CS_RISE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .WR_FIRST_PLANE(WR_FIRST_PLANE),
   .WR_SECOND_PLANE(WR_SECOND_PLANE), .SEGMENTS(SEGMENTS), .DIGIT_INDEX(DIGIT_INDEX),
   .BLINK_PHASE(BLINK_PHASE), .DECODE_SELECT(DECODE_SELECT));

/* bench/lsd_host_model.sv */
// Serial host model: one register or plane write per frame
`timescale 1ns/1ps
module lsd_host_model (
   input wire logic CLK,
   output logic WR_STB,
   output logic CS_RISE,
   output logic [7:0] WR_ADDR,
   output logic [7:0] WR_DATA,
   output logic WR_FIRST_PLANE,
   output logic WR_SECOND_PLANE,
   output logic [2:0] WR_DIGIT
);
   initial {WR_STB, CS_RISE, WR_FIRST_PLANE, WR_SECOND_PLANE, WR_ADDR, WR_DATA, WR_DIGIT} = '0;
   // ==========================================================
   // Frame: idle gap, strobe, chip-select rise; released lines show junk
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic [1:0] p,
      input logic [2:0] g);
      repeat (2) @(posedge CLK);
      {WR_STB, WR_FIRST_PLANE, WR_SECOND_PLANE, WR_ADDR, WR_DATA, WR_DIGIT} <= {1'b1, p, a, d, g};
      @(posedge CLK);
      {WR_STB, WR_FIRST_PLANE, WR_SECOND_PLANE, CS_RISE, WR_ADDR, WR_DATA} <= {4'h1, ~a, ~d};
      @(posedge CLK);
      CS_RISE <= 1'b0;
      @(negedge CLK);
   endtask : xfer
endmodule : lsd_host_model

/* bench/lsd_segment_top_bench.sv */
// Self-checking bench for the segment decode block
`timescale 1ns/1ps
module lsd_segment_top_bench;
   // ==========================================================
   // Setup
   localparam int FAST = 20;
   localparam int SLOW = 40;
   localparam logic [6:0] FONT [16] = '{7'h7e, 7'h30, 7'h6d, 7'h79, 7'h33, 7'h5b, 7'h5f, 7'h70,
      7'h7f, 7'h7b, 7'h77, 7'h1f, 7'h4e, 7'h3d, 7'h4f, 7'h47};
   logic clk, rstn, ce, dp, phase;
   logic stb, csr, fp, sp;
   logic [7:0] adr, dat, dsel;
   logic [7:0] snap_seg, snap_scan;
   logic [2:0] dg, dig;
   logic [6:0] seg;
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   lsd_segment_top #(.SLOW_PHASE_CYC(SLOW), .FAST_PHASE_CYC(FAST), .DIGIT_CYC(4)) uut (
      .CLK(clk), .RSTN(rstn), .CE(ce), .WR_STB(stb), .CS_RISE(csr), .WR_ADDR(adr),
      .WR_DATA(dat), .WR_FIRST_PLANE(fp), .WR_SECOND_PLANE(sp), .WR_DIGIT(dg), .SEGMENTS(seg),
      .DECIMAL_POINT_SEGMENT(dp), .DIGIT_INDEX(dig), .BLINK_PHASE(phase), .DECODE_SELECT(dsel));
   lsd_host_model h (.CLK(clk), .WR_STB(stb), .CS_RISE(csr), .WR_ADDR(adr), .WR_DATA(dat),
      .WR_FIRST_PLANE(fp), .WR_SECOND_PLANE(sp), .WR_DIGIT(dg));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // A hang counts as a failure
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         finish_test();
      end
   end
   // ==========================================================
   // Tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Let a full scan pass, then want three settled samples of digit g in phase ph (2 = any)
   task automatic look(input logic [2:0] g, input int ph, input logic [7:0] exp);
      int n;
      n = 0;
      repeat (34) @(negedge clk);
      while (n < 3) begin
         @(negedge clk);
         n = (dig === g && (ph == 2 || phase === ph[0])) ? n + 1 : 0;
      end
      check({dp, seg}, exp);
   endtask : look
   task automatic rate(input int exp);
      int n;
      logic o;
      @(phase);
      @(phase);
      o = phase;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (phase === o);
      check(8'(n - 1), 8'(exp));
   endtask : rate
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // ==========================================================
   // Tests
   initial begin
      rstn = 0;
      ce = 1;
      repeat (6) @(posedge clk);
      rstn <= 1;
      @(negedge clk);
      check(dsel, 8'h00);
      h.xfer(8'h01, 8'hff, 2'b00, 3'h0);
      check(dsel, 8'hff);
      h.xfer(8'h07, 8'h00, 2'b00, 3'h0);
      check(dsel, 8'hff);
      for (int c = 0; c < 16; c++) begin
         h.xfer(8'h00, {c[0], ~c[2:0], c[3:0]}, 2'b10, 3'h3);
         look(3'h3, 2, {c[0], FONT[c]});
      end
      h.xfer(8'h01, 8'hf7, 2'b00, 3'h0);
      h.xfer(8'h00, 8'ha5, 2'b10, 3'h3);
      look(3'h3, 2, 8'ha5);
      h.xfer(8'h04, 8'h0c, 2'b00, 3'h0);
      h.xfer(8'h00, 8'hc3, 2'b10, 3'h3);
      h.xfer(8'h00, 8'h96, 2'b01, 3'h3);
      h.xfer(8'h00, 8'h02, 2'b11, 3'h2);
      h.xfer(8'h00, 8'h83, 2'b01, 3'h2);
      look(3'h3, 0, 8'hc3);
      look(3'h3, 1, 8'h96);
      look(3'h2, 0, {1'b0, FONT[2]});
      look(3'h2, 1, {1'b1, FONT[3]});
      rate(FAST);
      h.xfer(8'h04, 8'h04, 2'b00, 3'h0);
      look(3'h3, 1, 8'hc3);
      h.xfer(8'h04, 8'h08, 2'b00, 3'h0);
      rate(SLOW);
      @(negedge clk iff (phase === 1'b1 && dig !== 3'h0));
      h.xfer(8'h04, 8'h18, 2'b00, 3'h0);
      // The shown index trails the internal scan index by one cycle
      repeat (2) @(negedge clk);
      check({4'h0, phase, dig}, 8'h00);
      @(posedge clk);
      ce <= 1'b0;
      @(negedge clk);
      snap_seg = {dp, seg};
      snap_scan = {4'h0, phase, dig};
      // A whole digit dwell passes with the enable low, so a moving scan would show
      repeat (4) @(negedge clk);
      check({dp, seg}, snap_seg);
      check({4'h0, phase, dig}, snap_scan);
      @(posedge clk);
      ce <= 1'b1;
      finish_test();
   end
endmodule : lsd_segment_top_bench
